// ---- inc/cfgld_pkg.sv ----
// Constants and types of the configuration load port
// Behaviour
// (RL1) Hold load-active low until init ends
// (RL2) Other party pulls load-active low to start
// (RL3) Ignore configuration pins while select is high
// (RL4) Other party keeps select low during load
// (RL5) Three mode pins choose the load mode
// (RL6) Clock input modes 1,2,3,6; driven 1 MHz 4,5
// (RL7) Sample and change on load clock rise
// (RL8) Dual pins are config only while line low
// (RL9) Lowest data pin: serial stream or byte LSB
// (RL10) Upper data pins used only in parallel modes
// (RL11) Modes 1,2,5 drive 17-bit memory address
// (RL12) Address changes only after load clock rise
// (RL13) Optional active-low cascade select output
// (RL14) Compare mode writes nothing, compares RAM
// (RL15) Difference drives mismatch flag low
// (RL16) Mismatch flag registered, held until restart
// (RL17) Bitstream format errors also set mismatch
// (RL18) Compare and mismatch can be switched off
// (RL19) Partial reload leaves other array running
// (RL20) Header: preamble, null+preamble, two preambles
// (RL21) Power-up user pins: TTL input with pull-up
// (RL22) Release line only after whole stream taken
package cfgld_pkg;
    // ==========================================
    // Timing
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned LCLK_HZ = 1000000;
    localparam int unsigned LCLK_HALF_CYC = CLK_HZ / (2 * LCLK_HZ);
    localparam int unsigned INIT_NS = 10000;
    localparam int unsigned INIT_CYC = INIT_NS / (1000000000 / CLK_HZ);
    // ==========================================
    // Register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_LENGTH = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_COUNT = 8'h0C;
    localparam logic [7:0] REG_IOCFG = 8'h10;
    localparam int CTRL_CMP_ALLOW = 0;
    localparam int CTRL_ERR_ALLOW = 1;
    localparam int CTRL_CASC_EN = 2;
    localparam logic [2:0] CTRL_RST = 3'h3;
    localparam logic [15:0] LENGTH_RST = 16'h1F8D;
    localparam int IOCFG_TTL = 0;
    localparam int IOCFG_PULLUP = 1;
    localparam int IOCFG_DRIVE = 2;
    localparam logic [2:0] IOCFG_RST = 3'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================
    // Bitstream
    localparam logic [7:0] PREAMBLE = 8'hA5;
    localparam logic [7:0] NULL_BYTE = 8'h00;
    localparam logic [2:0] MODE_PAR1 = 3'h1;
    localparam logic [2:0] MODE_PAR2 = 3'h2;
    localparam logic [2:0] MODE_SER3 = 3'h3;
    localparam logic [2:0] MODE_SER4 = 3'h4;
    localparam logic [2:0] MODE_PAR5 = 3'h5;
    localparam logic [2:0] MODE_PAR6 = 3'h6;
    // Sync vector: {cmp_n, upper[6:0], lsb, clk, mode[2:0], sel_n, act_n}
    localparam logic [14:0] SYNC_RST = 15'h4003;
    typedef enum logic [1:0] {ST_INIT, ST_REL, ST_WAIT, ST_LOAD} cfgld_state_e;
endpackage

// ---- src/cfgld_top.sv ----
// Configuration load port with AXI4-Lite control registers
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module cfgld_top import cfgld_pkg::*; #(
    parameter int CNT_W = 16,
    parameter int CRAM_AW = 14
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic i_load_active_n,
    output logic o_load_active_n,
    output logic o_load_active_oe,
    input wire logic i_load_sel_n,
    input wire logic [2:0] i_load_mode_sel,
    input wire logic i_load_clock,
    output logic o_load_clock,
    output logic o_load_clock_oe,
    input wire logic i_load_data_lsb,
    input wire logic [6:0] i_load_data_upper,
    output logic [16:0] o_prom_addr_out,
    output logic o_prom_addr_oe,
    output logic o_cascade_select_out_n,
    input wire logic i_compare_en_n,
    output logic o_mismatch_n,
    output logic o_mismatch_oe,
    output logic o_dual_cfg,
    output logic [CRAM_AW-1:0] o_cram_addr,
    output logic [7:0] o_cram_wdata,
    output logic o_cram_we,
    input wire logic [7:0] i_cram_rdata,
    output logic o_user_io_ttl,
    output logic o_user_io_pullup,
    output logic o_user_io_drive
);
    if (CNT_W < 15 || CNT_W > 16 || CRAM_AW < 1 || CRAM_AW > CNT_W) begin : g_chk
        $error("cfgld_top: unsupported CNT_W or CRAM_AW");
    end

    // ==========================================
    // Pin synchronisers
    logic [14:0] sync1_r;
    logic [14:0] sync2_r;
    logic lclk_d_r;
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            sync1_r <= SYNC_RST;
            sync2_r <= SYNC_RST;
            lclk_d_r <= 1'b0;
        end else begin
            sync1_r <= {i_compare_en_n, i_load_data_upper, i_load_data_lsb, i_load_clock,
                        i_load_mode_sel, i_load_sel_n, i_load_active_n};
            sync2_r <= sync1_r;
            lclk_d_r <= sync2_r[5];
        end
    end
    logic act_n_s;
    logic sel_n_s;
    logic [2:0] mode_s;
    logic lclk_s;
    logic lsb_s;
    logic [6:0] upper_s;
    logic cmp_n_s;
    assign act_n_s = sync2_r[0];
    assign sel_n_s = sync2_r[1];
    assign mode_s = sync2_r[4:2];
    assign lclk_s = sync2_r[5];
    assign lsb_s = sync2_r[6];
    assign upper_s = sync2_r[13:7];
    assign cmp_n_s = sync2_r[14];

    // ==========================================
    // Registers
    logic [2:0] ctrl_r;
    logic [15:0] len_r;
    logic [2:0] iocfg_r;
    cfgld_state_e st_r;
    logic [2:0] mode_r;
    logic cmp_r;
    logic done_r;
    logic mism_r;
    logic cfg_once_r;
    logic [CNT_W-1:0] idx_r;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ==========================================
    // AXI4-Lite write channel
    logic aw_hold_r;
    logic [7:0] awaddr_r;
    logic w_hold_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic wr_go;
    assign s_axi_awready = !aw_hold_r && !bvalid_r;
    assign s_axi_wready = !w_hold_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign wr_go = aw_hold_r && w_hold_r && !bvalid_r;

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            aw_hold_r <= 1'b0;
            awaddr_r <= 8'h00;
            w_hold_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                bvalid_r <= 1'b1;
                case ({awaddr_r[7:2], 2'b00})
                    REG_CTRL, REG_LENGTH, REG_STATUS, REG_COUNT, REG_IOCFG: bresp_r <= RESP_OKAY;
                    default: bresp_r <= RESP_SLVERR;
                endcase
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Control registers steer the load logic
    logic [31:0] ctrl_m;
    logic [31:0] len_m;
    logic [31:0] io_m;
    assign ctrl_m = merge({29'h0, ctrl_r}, wdata_r, wstrb_r);
    assign len_m = merge({16'h0, len_r}, wdata_r, wstrb_r);
    assign io_m = merge({29'h0, iocfg_r}, wdata_r, wstrb_r);
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_r <= CTRL_RST;
            len_r <= LENGTH_RST;
            iocfg_r <= IOCFG_RST;
        end else if (wr_go) begin
            if ({awaddr_r[7:2], 2'b00} == REG_CTRL) begin
                ctrl_r <= ctrl_m[2:0]; // see (RL18)
            end
            if ({awaddr_r[7:2], 2'b00} == REG_LENGTH) begin
                len_r <= len_m[15:0];
            end
            if ({awaddr_r[7:2], 2'b00} == REG_IOCFG) begin
                iocfg_r <= io_m[2:0];
            end
        end
    end

    // ==========================================
    // AXI4-Lite read channel
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rresp_r <= RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
                REG_CTRL: rdata_r <= {29'h0, ctrl_r};
                REG_LENGTH: rdata_r <= {16'h0, len_r};
                REG_STATUS: rdata_r <= {21'h0, mode_r, 2'b00, cmp_r, done_r, mism_r,
                                        cfg_once_r, st_r};
                REG_COUNT: rdata_r <= {{(32 - CNT_W){1'b0}}, idx_r};
                REG_IOCFG: rdata_r <= {29'h0, iocfg_r};
                default: begin
                    rdata_r <= 32'h0000_0000;
                    rresp_r <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ==========================================
    // Load sequencing
    logic [8:0] init_cnt_r;
    logic [1:0] hdr;
    logic [15:0] total;
    logic par_mode;
    logic addr_mode;
    logic int_clk;
    logic start;
    logic last_byte;
    logic byte_vld_r;
    logic [7:0] byte_r;
    always_comb begin
        par_mode = (mode_r == MODE_PAR1) || (mode_r == MODE_PAR2) || (mode_r == MODE_PAR5) ||
                   (mode_r == MODE_PAR6); // see (RL5)
        addr_mode = (mode_r == MODE_PAR1) || (mode_r == MODE_PAR2) ||
                    (mode_r == MODE_PAR5); // see (RL11)
        int_clk = (mode_r == MODE_SER4) || (mode_r == MODE_PAR5); // see (RL6)
        hdr = par_mode && (mode_r != MODE_PAR6) ? 2'd1 : 2'd2; // see (RL20)
    end
    assign total = len_r + {14'h0, hdr} - 16'h0001; // see (RL20)
    // Start only when this device is selected and the mode is a real one
    assign start = (st_r == ST_WAIT) && !act_n_s && !sel_n_s &&
                   (mode_s != 3'h0) && (mode_s != 3'h7); // see (RL2) (RL3) (RL5)
    assign last_byte = byte_vld_r && ({{(16 - CNT_W){1'b0}}, idx_r} == total - 16'h0001);

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_r <= ST_INIT;
            init_cnt_r <= 9'h000;
            done_r <= 1'b0;
            cfg_once_r <= 1'b0;
        end else begin
            case (st_r)
                ST_INIT: begin
                    init_cnt_r <= init_cnt_r + 9'h001;
                    if (init_cnt_r == 9'(INIT_CYC - 1)) begin
                        st_r <= ST_REL; // see (RL1)
                    end
                end
                ST_REL: begin
                    if (act_n_s) begin
                        st_r <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (start) begin
                        st_r <= ST_LOAD;
                        done_r <= 1'b0;
                    end
                end
                ST_LOAD: begin
                    if (last_byte) begin
                        st_r <= ST_REL; // see (RL22)
                        done_r <= 1'b1;
                        cfg_once_r <= 1'b1;
                    end
                end
                default: st_r <= ST_INIT;
            endcase
        end
    end

    // Mode and compare choice are caught at the start of a load
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            mode_r <= 3'h0;
            cmp_r <= 1'b0;
        end else if (start) begin
            mode_r <= mode_s; // see (RL5)
            cmp_r <= !cmp_n_s && ctrl_r[CTRL_CMP_ALLOW]; // see (RL14) (RL18)
        end
    end

    // Line held low in init and for the whole load
    assign o_load_active_n = 1'b0;
    assign o_load_active_oe = (st_r == ST_INIT) || (st_r == ST_LOAD); // see (RL1) (RL22)
    assign o_dual_cfg = !act_n_s; // see (RL8)

    // ==========================================
    // Load clock
    logic [4:0] div_r;
    logic lclk_out_r;
    logic int_rise;
    logic lclk_rise;
    assign int_rise = (div_r == 5'(LCLK_HALF_CYC - 1)) && !lclk_out_r;
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            div_r <= 5'h00;
            lclk_out_r <= 1'b0;
        end else if ((st_r == ST_LOAD && int_clk) || lclk_out_r) begin
            if (div_r == 5'(LCLK_HALF_CYC - 1)) begin
                div_r <= 5'h00;
                lclk_out_r <= !lclk_out_r; // see (RL6)
            end else begin
                div_r <= div_r + 5'h01;
            end
        end else begin
            div_r <= 5'h00;
            lclk_out_r <= 1'b0;
        end
    end
    assign o_load_clock = lclk_out_r;
    assign o_load_clock_oe = (st_r == ST_LOAD) && int_clk; // see (RL6)
    // Rising edges only, and none while deselected
    assign lclk_rise = (st_r == ST_LOAD) && !sel_n_s &&
                       (int_clk ? int_rise : (lclk_s && !lclk_d_r)); // see (RL3) (RL4) (RL7)

    // ==========================================
    // Byte capture
    logic [2:0] bit_cnt_r;
    logic [7:0] shift_r;
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            bit_cnt_r <= 3'h0;
            shift_r <= 8'h00;
            byte_vld_r <= 1'b0;
            byte_r <= 8'h00;
        end else begin
            byte_vld_r <= 1'b0;
            if (start) begin
                bit_cnt_r <= 3'h0;
            end else if (lclk_rise) begin
                if (par_mode) begin
                    byte_r <= {upper_s, lsb_s}; // see (RL9) (RL10)
                    byte_vld_r <= 1'b1;
                end else begin
                    // Serial: lowest pin only, first bit is the byte LSB
                    shift_r <= {lsb_s, shift_r[7:1]}; // see (RL9) (RL10)
                    bit_cnt_r <= bit_cnt_r + 3'h1;
                    if (bit_cnt_r == 3'h7) begin
                        byte_r <= {lsb_s, shift_r[7:1]};
                        byte_vld_r <= 1'b1;
                    end
                end
            end
        end
    end

    // ==========================================
    // Header check, RAM write or compare, address
    logic pay_vld_r;
    logic [CRAM_AW-1:0] cram_addr_r;
    logic [7:0] cram_data_r;
    logic hdr_err_r;
    logic [16:0] prom_addr_r;
    logic is_hdr;
    logic [7:0] hdr_exp;
    logic [15:0] pay_idx;
    logic cmp_miss;
    assign is_hdr = {{(16 - CNT_W){1'b0}}, idx_r} < {14'h0, hdr};
    assign hdr_exp = (!par_mode && idx_r == '0) ? NULL_BYTE : PREAMBLE; // see (RL20)
    assign pay_idx = {{(16 - CNT_W){1'b0}}, idx_r} - {14'h0, hdr};
    assign cmp_miss = pay_vld_r && cmp_r && (i_cram_rdata != cram_data_r); // see (RL14)

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            idx_r <= '0;
            pay_vld_r <= 1'b0;
            cram_addr_r <= '0;
            cram_data_r <= 8'h00;
            hdr_err_r <= 1'b0;
            prom_addr_r <= 17'h00000;
        end else begin
            pay_vld_r <= 1'b0;
            hdr_err_r <= 1'b0;
            if (start) begin
                idx_r <= '0;
                prom_addr_r <= 17'h00000;
            end else if (byte_vld_r) begin
                idx_r <= idx_r + 1'b1;
                prom_addr_r <= prom_addr_r + 17'h00001; // see (RL12)
                if (is_hdr) begin
                    hdr_err_r <= byte_r != hdr_exp; // see (RL17)
                end else begin
                    // Only the addressed words change; the array keeps running
                    pay_vld_r <= 1'b1; // see (RL19)
                    cram_addr_r <= pay_idx[CRAM_AW-1:0];
                    cram_data_r <= byte_r;
                end
            end
        end
    end
    assign o_cram_addr = cram_addr_r;
    assign o_cram_wdata = cram_data_r;
    assign o_cram_we = pay_vld_r && !cmp_r; // see (RL14)
    assign o_prom_addr_out = prom_addr_r;
    assign o_prom_addr_oe = (st_r == ST_LOAD) && addr_mode; // see (RL11)

    // ==========================================
    // Mismatch flag and cascade select
    logic cascade_select_out_n_n_r;
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            mism_r <= 1'b0;
        end else if (ctrl_r[CTRL_ERR_ALLOW] && (cmp_miss || hdr_err_r)) begin
            mism_r <= 1'b1; // see (RL15) (RL17)
        end else if (start) begin
            mism_r <= 1'b0; // see (RL16)
        end
    end
    assign o_mismatch_n = !mism_r;
    assign o_mismatch_oe = o_dual_cfg && ctrl_r[CTRL_ERR_ALLOW]; // see (RL18)

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            cascade_select_out_n_n_r <= 1'b1;
        end else begin
            cascade_select_out_n_n_r <= !(ctrl_r[CTRL_CASC_EN] && done_r && !sel_n_s && !start); // see (RL13)
        end
    end
    assign o_cascade_select_out_n = cascade_select_out_n_n_r;

    // User pins stay TTL inputs with pull-up until the first load ends
    assign o_user_io_ttl = cfg_once_r ? iocfg_r[IOCFG_TTL] : 1'b1; // see (RL21)
    assign o_user_io_pullup = cfg_once_r ? iocfg_r[IOCFG_PULLUP] : 1'b1;
    assign o_user_io_drive = cfg_once_r ? iocfg_r[IOCFG_DRIVE] : 1'b0;

    // ==========================================
    // Assertions
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);

    sequence byte_take;
        byte_vld_r && !start;
    endsequence
    sequence addr_step;
        o_prom_addr_out == $past(o_prom_addr_out) + 17'h00001;
    endsequence

    init_hold_a: assert property (st_r == ST_INIT |-> o_load_active_oe) // see (RL1)
        else $error("load-active released during init");
    sel_ignore_a: assert property (sel_n_s && st_r == ST_LOAD |=> !byte_vld_r) // see (RL3)
        else $error("byte taken while deselected");
    clk_drive_a: assert property (o_load_clock_oe == (st_r == ST_LOAD && // see (RL6)
        (mode_r == MODE_SER4 || mode_r == MODE_PAR5)))
        else $error("load clock drive in wrong mode");
    clk_half_a: assert property ($rose(o_load_clock) |=> // see (RL6)
        (!$fell(o_load_clock))[*8])
        else $error("load clock half period too short");
    addr_step_a: assert property (byte_take |=> addr_step) // see (RL12)
        else $error("memory address not stepped after byte");
    cmp_nowrite_a: assert property (cmp_r |-> !o_cram_we) // see (RL14)
        else $error("RAM written in compare mode");
    miss_set_a: assert property (cmp_miss && ctrl_r[CTRL_ERR_ALLOW] |=> // see (RL15)
        !o_mismatch_n)
        else $error("mismatch not flagged");
    miss_hold_a: assert property (!o_mismatch_n && !start |=> !o_mismatch_n) // see (RL16)
        else $error("mismatch flag dropped before restart");
    release_done_a: assert property ($fell(o_load_active_oe) && // see (RL22)
        !$past(st_r == ST_INIT) |-> $past(last_byte))
        else $error("line released before whole stream");
    io_default_a: assert property (!cfg_once_r |-> o_user_io_ttl && // see (RL21)
        o_user_io_pullup && !o_user_io_drive)
        else $error("user pins not at power-up default");
    casc_sel_a: assert property (!o_cascade_select_out_n |-> $past(done_r)) // see (RL13)
        else $error("cascade select before load done");
endmodule
`default_nettype wire

// ---- bench/cfgld_src.sv ----
// Model of the configuration source that feeds the load pins
`timescale 1ns/100ps
`default_nettype none
module cfgld_src import cfgld_pkg::*; (
    input wire logic i_go,
    input wire logic [2:0] i_mode,
    input wire logic i_dev_clk,
    input wire logic i_dev_oe,
    output logic o_clk,
    output logic [7:0] o_data,
    output logic o_busy
);
    logic [7:0] mem [0:7];
    logic ser;
    int n;
    int i;
    initial begin
        {o_clk, o_data, o_busy} = '0;
        forever begin
            @(posedge i_go);
            o_busy = 1'b1;
            ser = (i_mode == MODE_SER3 || i_mode == MODE_SER4);
            for (i = 0; i < n * (ser ? 8 : 1); i++) begin
                o_data = ser ? {~mem[i / 8][7:1], mem[i / 8][i % 8]} : mem[i];
                if (i_dev_oe) @(posedge i_dev_clk);
                else begin
                    #160 o_clk = 1'b1;
                    #160 o_clk = 1'b0;
                end
            end
            #480 o_data = ~o_data;
            o_busy = 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking testbench of the configuration load port
`timescale 1ns/100ps
`default_nettype none
module testbench import cfgld_pkg::*;;
    // ==========================================
    // Signals and instances
    logic i_mclk, i_rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pull, go;
    logic o_load_active_oe, o_load_clock, o_load_clock_oe, o_prom_addr_oe, o_dual_cfg, o_cram_we;
    logic i_load_sel_n, i_compare_en_n, o_cascade_select_out_n, o_mismatch_n, sclk, busy;
    logic o_user_io_ttl, o_user_io_pullup, o_user_io_drive, o_mismatch_oe;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] i_load_mode_sel;
    logic [7:0] s_axi_awaddr, s_axi_araddr, o_cram_wdata, sdata;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [16:0] o_prom_addr_out;
    logic [13:0] o_cram_addr;
    logic [7:0] cram [0:15];
    int mismatches = 0;
    int total_checks = 0;
    cfgld_top u_dut (.i_mclk, .i_rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .i_load_active_n(!(o_load_active_oe || pull)), .o_load_active_n(),
        .o_load_active_oe, .i_load_sel_n, .i_load_mode_sel, .o_load_clock, .o_load_clock_oe,
        .i_load_clock(o_load_clock_oe ? o_load_clock : sclk), .i_load_data_lsb(sdata[0]),
        .i_load_data_upper(sdata[7:1]), .o_prom_addr_out, .o_prom_addr_oe, .o_cascade_select_out_n,
        .i_compare_en_n, .o_mismatch_n, .o_mismatch_oe, .o_dual_cfg, .o_cram_addr, .o_cram_wdata,
        .o_cram_we, .i_cram_rdata(cram[o_cram_addr[3:0]]), .o_user_io_ttl, .o_user_io_pullup,
        .o_user_io_drive);
    cfgld_src u_src (.i_go(go), .i_mode(i_load_mode_sel), .i_dev_clk(o_load_clock),
        .i_dev_oe(o_load_clock_oe), .o_clk(sclk), .o_data(sdata), .o_busy(busy));
    initial begin
        i_mclk = 1'b0;
        forever #20 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) if (o_cram_we) cram[o_cram_addr[3:0]] <= o_cram_wdata;
    // ==========================================
    // Tasks
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch at %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic tmo(input int n);
        if (n >= 9000) begin
            mismatches++;
            wrap_up();
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (n = 0; n < 9000 && !s_axi_bvalid; n++) begin
            @(posedge i_mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, e);
        tmo(n);
        @(posedge i_mclk);
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        int n;
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (n = 0; n < 9000 && !s_axi_rvalid; n++) begin
            @(posedge i_mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        chk(s_axi_rresp, r);
        if (r == RESP_OKAY) chk(s_axi_rdata, e);
        tmo(n);
        @(posedge i_mclk);
    endtask
    task automatic run(input logic [2:0] m, input logic c, input logic [7:0] bad, x);
        int h, n, k;
        logic par;
        h = (m == MODE_SER3 || m == MODE_SER4 || m == MODE_PAR6) ? 2 : 1;
        n = 3 + h;
        par = (m == MODE_PAR1 || m == MODE_PAR2 || m == MODE_PAR5);
        for (k = 0; k < n; k++) u_src.mem[k] = (k < h) ? PREAMBLE : 8'(8'h10 * m + k);
        if (h == 2 && m != MODE_PAR6) u_src.mem[0] = NULL_BYTE;
        u_src.mem[0] ^= bad;
        u_src.mem[h + 1] ^= x;
        u_src.n = n;
        i_load_mode_sel <= m;
        i_compare_en_n <= c;
        {i_load_sel_n, pull} <= 2'h1;
        repeat (6) @(posedge i_mclk);
        {pull, go} <= 2'h1;
        @(posedge i_mclk);
        go <= 1'b0;
        chk({o_load_active_oe, o_dual_cfg, o_prom_addr_oe, o_load_clock_oe, o_mismatch_oe},
            {2'h3, par, m == MODE_SER4 || m == MODE_PAR5, 1'b1});
        for (k = 0; k < 9000 && (o_load_active_oe || busy); k++) @(posedge i_mclk);
        tmo(k);
        repeat (3) @(posedge i_mclk);
        chk({o_dual_cfg, o_mismatch_n, o_cascade_select_out_n},
            {1'b0, bad == 0 && x == 0, 1'b0});
        if (par) chk(o_prom_addr_out, n);
        if (bad == 0) for (k = 0; k < 3; k++) chk(cram[k], 8'h10 * m + k + h);
        i_load_sel_n <= 1'b1;
        repeat (4) @(posedge i_mclk);
    endtask
    // ==========================================
    // Main sequence
    initial begin
        int k;
        {i_rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {pull, go, i_load_mode_sel, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {i_load_sel_n, i_compare_en_n} = 2'h3;
        repeat (10) @(posedge i_mclk);
        chk({o_load_active_oe, o_mismatch_n, o_user_io_ttl, o_user_io_pullup,
            o_user_io_drive}, 5'h1E);
        i_rstn <= 1'b1;
        repeat (200) @(posedge i_mclk);
        chk(o_load_active_oe, 1'b1);
        for (k = 0; k < 9000 && o_load_active_oe; k++) @(posedge i_mclk);
        tmo(k);
        axr(REG_CTRL, 32'h3, RESP_OKAY);
        axr(REG_LENGTH, 32'h1F8D, RESP_OKAY);
        axr(REG_IOCFG, 32'h3, RESP_OKAY);
        axr(8'h14, 32'h0, RESP_SLVERR);
        axw(REG_LENGTH, 32'h4, RESP_OKAY);
        axw(REG_CTRL, 32'h7, RESP_OKAY);
        {i_load_mode_sel, pull} <= {MODE_PAR1, 1'b1};
        repeat (10) @(posedge i_mclk);
        pull <= 1'b0;
        repeat (4) @(posedge i_mclk);
        chk(o_load_active_oe, 1'b0);
        for (k = 1; k <= 6; k++) run(3'(k), 1'b1, 8'h00, 8'h00);
        run(MODE_PAR6, 1'b0, 8'h00, 8'h00);
        run(MODE_PAR6, 1'b0, 8'h00, 8'h01);
        run(MODE_PAR1, 1'b1, 8'hFF, 8'h00);
        run(MODE_PAR2, 1'b1, 8'h00, 8'h00);
        axr(REG_STATUS, 32'h216, RESP_OKAY);
        wrap_up();
    end
endmodule
`default_nettype wire
